//--- inc/hmsg_defs.vh
// Constants for the fault group two and measuring status register groups
// Function
// - Event register clears on query and clear-status
// - Fault group two summary drives status bit one
// - Measuring summary routes toward status bit seven
// - Measuring summary passes to status bit seven only when operation-enabled
// - Fault group two bits 12 to 15 zero
// - Bits 11, 10: adjacent-channel bandwidth faults
// - Bits 9, 8: audio generator limit faults
// - Bits 7, 6: modulation request faults
// - Bits 5, 4, 3: ranging and tuning errors
// - Bit 2: offset frequency combination impossible
// - Bits 1, 0: port level faults
// - Measuring group implements only bit 0
// - Separate readable writable rise and fall filters
// - Enable register readable and loadable
// - Summary set while enabled events are pending
`ifndef HMSG_DEFS_VH
`define HMSG_DEFS_VH

// ----------------------------------------------------------------
// Groups and register selectors
// ----------------------------------------------------------------
`define HMSG_GRP_HW2 1'b0
`define HMSG_GRP_MEAS 1'b1
`define HMSG_SEL_COND 3'h0
`define HMSG_SEL_RISE 3'h1
`define HMSG_SEL_FALL 3'h2
`define HMSG_SEL_EVENT 3'h3
`define HMSG_SEL_ENABLE 3'h4

// ----------------------------------------------------------------
// Implemented bit masks and reset values
// ----------------------------------------------------------------
`define HMSG_HW2_MASK 16'h0fff
`define HMSG_MEAS_MASK 16'h0001
`define HMSG_RISE_RST 16'hffff
`define HMSG_FALL_RST 16'h0000
`define HMSG_EVENT_RST 16'h0000
`define HMSG_ENABLE_RST 16'h0000

// ----------------------------------------------------------------
// Status byte and operation group positions
// ----------------------------------------------------------------
`define HMSG_STB_HW2_BIT 1
`define HMSG_STB_OPER_BIT 7
`define HMSG_OPER_MEAS_BIT 4

`endif

//--- logic/hmsg_group.v
// One status register group: condition, filters, event and enable
`include "hmsg_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module hmsg_group #(
    parameter WIDTH = 16,
    parameter [15:0] IMPL_MASK = 16'hffff
) (
    input wire mclk,
    input wire rst_n,
    input wire [WIDTH-1:0] cond_in,
    input wire rise_wr,
    input wire fall_wr,
    input wire enable_wr,
    input wire [WIDTH-1:0] wr_data,
    input wire event_rd,
    input wire clear_status,
    output reg [WIDTH-1:0] cond_reg,
    output reg [WIDTH-1:0] rise_reg,
    output reg [WIDTH-1:0] fall_reg,
    output reg [WIDTH-1:0] event_reg,
    output reg [WIDTH-1:0] enable_reg,
    output wire summary
);

    wire [WIDTH-1:0] mask = IMPL_MASK[WIDTH-1:0];
    wire [WIDTH-1:0] cond_next = cond_in & mask;
    wire [WIDTH-1:0] edge_set;
    reg [WIDTH-1:0] event_next;

    // Rising edge passes the rise filter, falling edge the fall filter
    assign edge_set = ((cond_next & ~cond_reg) & rise_reg) |
                      ((~cond_next & cond_reg) & fall_reg);

    // A new edge in the clearing cycle is kept
    always @* begin
        event_next = event_reg;
        if (event_rd || clear_status) begin
            event_next = {WIDTH{1'b0}};
        end
        event_next = (event_next | edge_set) & mask;
    end

    assign summary = |(event_reg & enable_reg);

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cond_reg <= {WIDTH{1'b0}};
            rise_reg <= `HMSG_RISE_RST;
            fall_reg <= `HMSG_FALL_RST;
            event_reg <= `HMSG_EVENT_RST;
            enable_reg <= `HMSG_ENABLE_RST;
        end else begin
            cond_reg <= cond_next;
            event_reg <= event_next;
            if (rise_wr) begin
                rise_reg <= wr_data;
            end
            if (fall_wr) begin
                fall_reg <= wr_data;
            end
            if (enable_wr) begin
                enable_reg <= wr_data;
            end
        end
    end

endmodule // hmsg_group

`default_nettype wire

//--- logic/hmsg_status.v
// Top of the fault group two and measuring status register groups
`include "hmsg_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module hmsg_status #(
    parameter WIDTH = 16
) (
    input wire mclk,
    input wire nrst,
    // Fault group two condition sources
    input wire acp_bw_inconsistent,
    input wire acp_bw_offset_too_wide,
    input wire audio_gen_one_notch_range,
    input wire audio_gen_two_volt_too_large,
    input wire fm_dev_too_large,
    input wire am_fm_simultaneous,
    input wire audio_autorange_err,
    input wire rf_level_autorange_err,
    input wire rf_freq_autotune_err,
    input wire rf_offset_mismatch,
    input wire gen_ampl_too_high,
    input wire ana_ref_level_bad,
    // Measuring condition source
    input wire frame_error_rate_running,
    // Operation group enable bit for the measuring summary
    input wire oper_meas_enable,
    // Status command port
    input wire cmd_valid,
    input wire cmd_write,
    input wire cmd_group,
    input wire [2:0] cmd_sel,
    input wire [WIDTH-1:0] cmd_wdata,
    input wire clear_status,
    output reg [WIDTH-1:0] rd_data,
    output reg rd_valid,
    // Summary message bits
    output reg [7:0] status_byte_bits,
    output reg meas_summary_message_bit
);

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    reg rst_sync1_reg;
    reg rst_sync2_reg;

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_sync1_reg <= 1'b0;
            rst_sync2_reg <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_sync2_reg <= rst_sync1_reg;
        end
    end

    wire rst_n = rst_sync2_reg;

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    function hit;
        input grp;
        input [2:0] sel;
        input want_grp;
        input [2:0] want_sel;
        begin
            hit = (grp == want_grp) && (sel == want_sel);
        end
    endfunction

    wire wr = cmd_valid && cmd_write;
    wire rd = cmd_valid && !cmd_write;

    wire hw_rise_wr = wr && hit(cmd_group, cmd_sel, `HMSG_GRP_HW2, `HMSG_SEL_RISE);
    wire hw_fall_wr = wr && hit(cmd_group, cmd_sel, `HMSG_GRP_HW2, `HMSG_SEL_FALL);
    wire hw_en_wr = wr && hit(cmd_group, cmd_sel, `HMSG_GRP_HW2, `HMSG_SEL_ENABLE);
    wire hw_ev_rd = rd && hit(cmd_group, cmd_sel, `HMSG_GRP_HW2, `HMSG_SEL_EVENT);
    wire ms_rise_wr = wr && hit(cmd_group, cmd_sel, `HMSG_GRP_MEAS, `HMSG_SEL_RISE);
    wire ms_fall_wr = wr && hit(cmd_group, cmd_sel, `HMSG_GRP_MEAS, `HMSG_SEL_FALL);
    wire ms_en_wr = wr && hit(cmd_group, cmd_sel, `HMSG_GRP_MEAS, `HMSG_SEL_ENABLE);
    wire ms_ev_rd = rd && hit(cmd_group, cmd_sel, `HMSG_GRP_MEAS, `HMSG_SEL_EVENT);

    // ----------------------------------------------------------------
    // Condition inputs
    // ----------------------------------------------------------------
    wire [WIDTH-1:0] hw_cond_in;
    wire [WIDTH-1:0] ms_cond_in;

    assign hw_cond_in[15:12] = 4'h0;
    assign hw_cond_in[11] = acp_bw_inconsistent;
    assign hw_cond_in[10] = acp_bw_offset_too_wide;
    assign hw_cond_in[9] = audio_gen_one_notch_range;
    assign hw_cond_in[8] = audio_gen_two_volt_too_large;
    assign hw_cond_in[7] = fm_dev_too_large;
    assign hw_cond_in[6] = am_fm_simultaneous;
    assign hw_cond_in[5] = audio_autorange_err;
    assign hw_cond_in[4] = rf_level_autorange_err;
    assign hw_cond_in[3] = rf_freq_autotune_err;
    assign hw_cond_in[2] = rf_offset_mismatch;
    assign hw_cond_in[1] = gen_ampl_too_high;
    assign hw_cond_in[0] = ana_ref_level_bad;
    assign ms_cond_in = {15'h0000, frame_error_rate_running};

    // ----------------------------------------------------------------
    // Groups
    // ----------------------------------------------------------------
    wire [WIDTH-1:0] hw_cond, hw_rise, hw_fall, hw_event, hw_enable;
    wire [WIDTH-1:0] ms_cond, ms_rise, ms_fall, ms_event, ms_enable;
    wire hw_summary;
    wire ms_summary;

    hmsg_group #(
        .WIDTH(WIDTH),
        .IMPL_MASK(`HMSG_HW2_MASK)
    ) u_hw_fault_group_two (
        .mclk(mclk),
        .rst_n(rst_n),
        .cond_in(hw_cond_in),
        .rise_wr(hw_rise_wr),
        .fall_wr(hw_fall_wr),
        .enable_wr(hw_en_wr),
        .wr_data(cmd_wdata),
        .event_rd(hw_ev_rd),
        .clear_status(clear_status),
        .cond_reg(hw_cond),
        .rise_reg(hw_rise),
        .fall_reg(hw_fall),
        .event_reg(hw_event),
        .enable_reg(hw_enable),
        .summary(hw_summary)
    );

    hmsg_group #(
        .WIDTH(WIDTH),
        .IMPL_MASK(`HMSG_MEAS_MASK)
    ) u_measuring_group (
        .mclk(mclk),
        .rst_n(rst_n),
        .cond_in(ms_cond_in),
        .rise_wr(ms_rise_wr),
        .fall_wr(ms_fall_wr),
        .enable_wr(ms_en_wr),
        .wr_data(cmd_wdata),
        .event_rd(ms_ev_rd),
        .clear_status(clear_status),
        .cond_reg(ms_cond),
        .rise_reg(ms_rise),
        .fall_reg(ms_fall),
        .event_reg(ms_event),
        .enable_reg(ms_enable),
        .summary(ms_summary)
    );

    // ----------------------------------------------------------------
    // Read mux and summary routing
    // ----------------------------------------------------------------
    reg [WIDTH-1:0] rd_next;
    reg [7:0] stb_next;

    always @* begin
        rd_next = {WIDTH{1'b0}};
        case ({cmd_group, cmd_sel})
            {`HMSG_GRP_HW2, `HMSG_SEL_COND}: rd_next = hw_cond;
            {`HMSG_GRP_HW2, `HMSG_SEL_RISE}: rd_next = hw_rise;
            {`HMSG_GRP_HW2, `HMSG_SEL_FALL}: rd_next = hw_fall;
            {`HMSG_GRP_HW2, `HMSG_SEL_EVENT}: rd_next = hw_event;
            {`HMSG_GRP_HW2, `HMSG_SEL_ENABLE}: rd_next = hw_enable;
            {`HMSG_GRP_MEAS, `HMSG_SEL_COND}: rd_next = ms_cond;
            {`HMSG_GRP_MEAS, `HMSG_SEL_RISE}: rd_next = ms_rise;
            {`HMSG_GRP_MEAS, `HMSG_SEL_FALL}: rd_next = ms_fall;
            {`HMSG_GRP_MEAS, `HMSG_SEL_EVENT}: rd_next = ms_event;
            {`HMSG_GRP_MEAS, `HMSG_SEL_ENABLE}: rd_next = ms_enable;
            default: rd_next = {WIDTH{1'b0}};
        endcase
    end

    always @* begin
        stb_next = 8'h00;
        stb_next[`HMSG_STB_HW2_BIT] = hw_summary;
        stb_next[`HMSG_STB_OPER_BIT] = ms_summary && oper_meas_enable;
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= {WIDTH{1'b0}};
            rd_valid <= 1'b0;
            status_byte_bits <= 8'h00;
            meas_summary_message_bit <= 1'b0;
        end else begin
            rd_valid <= rd;
            if (rd) begin
                rd_data <= rd_next;
            end
            status_byte_bits <= stb_next;
            meas_summary_message_bit <= ms_summary;
        end
    end

endmodule // hmsg_status

`default_nettype wire

//--- tb/hmsg_status_sva.sv
// Assertions on the command port and summary outputs of the status groups
`include "hmsg_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module hmsg_status_sva #(
    parameter WIDTH = 16
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic oper_meas_enable,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic cmd_group,
    input wire logic [2:0] cmd_sel,
    input wire logic [WIDTH-1:0] rd_data,
    input wire logic rd_valid,
    input wire logic [7:0] status_byte_bits,
    input wire logic meas_summary_message_bit
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire logic qry = cmd_valid && !cmd_write;
    logic [2:0] sel_q = 3'h0;
    // Selector of the command taken at the previous edge
    always @(posedge mclk) begin
        sel_q <= cmd_sel;
    end
    wire logic pick = sel_q == `HMSG_SEL_COND || sel_q == `HMSG_SEL_EVENT;
    query_answer_a: assert property (qry |=> rd_valid)
        else $error("query not answered");
    answer_only_a: assert property (!qry |=> !rd_valid)
        else $error("stray answer strobe");
    read_hold_a: assert property (!rd_valid |-> $stable(rd_data))
        else $error("answer changed without query");
    unused_stb_a: assert property (status_byte_bits[6:2] == 5'h00 && !status_byte_bits[0])
        else $error("unused status bit set");
    meas_gate_a: assert property (status_byte_bits[7] ==
        (meas_summary_message_bit && $past(oper_meas_enable)))
        else $error("status bit seven not gated");
    hw_top_zero_a: assert property (rd_valid && pick && $past(cmd_group) == `HMSG_GRP_HW2
        |-> rd_data[15:12] == 4'h0)
        else $error("fault group top bits not zero");
    meas_top_zero_a: assert property (rd_valid && pick && $past(cmd_group) == `HMSG_GRP_MEAS
        |-> rd_data[15:1] == 15'h0000)
        else $error("measuring unused bits not zero");
    unmapped_zero_a: assert property (rd_valid && $past(cmd_sel) > 3'h4 |-> rd_data == 16'h0000)
        else $error("unmapped query not zero");
    cover property (qry && cmd_group);
    cover property (status_byte_bits[1]);
    cover property (status_byte_bits[7]);
endmodule // hmsg_status_sva
`default_nettype wire

//--- tb/hmsg_ctl.sv
// Controller model that issues status commands
`timescale 1ns/1ps
`default_nettype none
module hmsg_ctl (
    input wire logic mclk,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid,
    output logic cmd_valid = 1'b0,
    output logic cmd_write = 1'b0,
    output logic cmd_group = 1'b0,
    output logic [2:0] cmd_sel = 3'h0,
    output logic [15:0] cmd_wdata = 16'h0000,
    output logic clear_status = 1'b0
);
    // One strobe per command, data inverted once released
    task automatic put(input logic w, input logic g, input logic [2:0] s, input logic [15:0] d);
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_group <= g;
        cmd_sel <= s;
        cmd_wdata <= d;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        cmd_wdata <= ~d;
    endtask
    task automatic ask(input logic g, input logic [2:0] s, output logic [15:0] q);
        put(1'b0, g, s, 16'h0000);
        @(negedge mclk);
        q = rd_valid ? rd_data : 16'hxxxx;
    endtask
    task automatic clr;
        @(posedge mclk);
        clear_status <= 1'b1;
        @(posedge mclk);
        clear_status <= 1'b0;
    endtask
endmodule // hmsg_ctl
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the fault group two and measuring status groups
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [11:0] hw = 12'h000;
    logic frame_error_rate = 1'b0;
    logic oper = 1'b0;
    wire logic cmd_valid, cmd_write, cmd_group, clear_status;
    wire logic [2:0] cmd_sel;
    wire logic [15:0] cmd_wdata;
    logic [15:0] rd_data, q;
    logic rd_valid, msb;
    logic [7:0] stb;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #2.5 mclk = ~mclk;
    hmsg_status DUT (.mclk(mclk), .nrst(nrst), .acp_bw_inconsistent(hw[11]),
        .acp_bw_offset_too_wide(hw[10]), .audio_gen_one_notch_range(hw[9]),
        .audio_gen_two_volt_too_large(hw[8]), .fm_dev_too_large(hw[7]),
        .am_fm_simultaneous(hw[6]), .audio_autorange_err(hw[5]), .rf_level_autorange_err(hw[4]),
        .rf_freq_autotune_err(hw[3]), .rf_offset_mismatch(hw[2]), .gen_ampl_too_high(hw[1]),
        .ana_ref_level_bad(hw[0]), .frame_error_rate_running(frame_error_rate), .oper_meas_enable(oper),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_group(cmd_group), .cmd_sel(cmd_sel),
        .cmd_wdata(cmd_wdata), .clear_status(clear_status), .rd_data(rd_data),
        .rd_valid(rd_valid), .status_byte_bits(stb), .meas_summary_message_bit(msb));
    hmsg_ctl ctl (.mclk(mclk), .rd_data(rd_data), .rd_valid(rd_valid), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_group(cmd_group), .cmd_sel(cmd_sel),
        .cmd_wdata(cmd_wdata), .clear_status(clear_status));
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rd(input logic g, input logic [2:0] s, input logic [15:0] e, input string nm);
        ctl.ask(g, s, q);
        chk(nm, q, e);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        wt(5);
        nrst <= 1'b1;
        wt(4);
        for (int g = 0; g < 2; g++) begin
            rd(g[0], 3'h1, 16'hffff, "rise reset");
            rd(g[0], 3'h2, 16'h0000, "fall reset");
            rd(g[0], 3'h3, 16'h0000, "event reset");
            rd(g[0], 3'h4, 16'h0000, "enable reset");
        end
        $display("test reset values done");
        ctl.put(1'b1, 1'b0, 3'h2, 16'ha5c3);
        ctl.put(1'b1, 1'b1, 3'h4, 16'h5a3c);
        ctl.put(1'b1, 1'b0, 3'h0, 16'hffff);
        ctl.put(1'b1, 1'b0, 3'h3, 16'hffff);
        rd(1'b0, 3'h2, 16'ha5c3, "fall readback");
        rd(1'b1, 3'h4, 16'h5a3c, "enable readback");
        rd(1'b0, 3'h0, 16'h0000, "cond write refused");
        rd(1'b0, 3'h3, 16'h0000, "event write refused");
        rd(1'b0, 3'h5, 16'h0000, "unmapped");
        ctl.put(1'b1, 1'b0, 3'h2, 16'h0000);
        ctl.put(1'b1, 1'b0, 3'h4, 16'h0fff);
        $display("test access done");
        for (int i = 0; i < 12; i++) begin
            @(posedge mclk) hw <= 12'h001 << i;
            wt(3);
            chk("summary on", {15'h0000, stb[1]}, 16'h0001);
            rd(1'b0, 3'h0, 16'h0001 << i, "cond bit");
            rd(1'b0, 3'h3, 16'h0001 << i, "event bit");
            rd(1'b0, 3'h3, 16'h0000, "event cleared");
            wt(2);
            chk("summary off", {15'h0000, stb[1]}, 16'h0000);
            @(posedge mclk) hw <= 12'h000;
        end
        $display("test fault bits done");
        ctl.put(1'b1, 1'b0, 3'h1, 16'h0000);
        ctl.put(1'b1, 1'b0, 3'h2, 16'hffff);
        @(posedge mclk) hw <= 12'h008;
        wt(3);
        rd(1'b0, 3'h3, 16'h0000, "rise filtered");
        @(posedge mclk) hw <= 12'h000;
        wt(3);
        rd(1'b0, 3'h3, 16'h0008, "fall event");
        $display("test filters done");
        ctl.put(1'b1, 1'b1, 3'h4, 16'h0001);
        @(posedge mclk) frame_error_rate <= 1'b1;
        wt(3);
        chk("meas summary", {15'h0000, msb}, 16'h0001);
        chk("bit seven gated", {15'h0000, stb[7]}, 16'h0000);
        @(posedge mclk) oper <= 1'b1;
        wt(2);
        chk("bit seven", {15'h0000, stb[7]}, 16'h0001);
        rd(1'b1, 3'h0, 16'h0001, "measuring_condition");
        ctl.clr();
        wt(2);
        chk("cleared summary", {15'h0000, msb}, 16'h0000);
        rd(1'b1, 3'h3, 16'h0000, "meas event cleared");
        $display("test measuring done");
        @(posedge mclk) nrst <= 1'b0;
        wt(2);
        chk("reset status", {8'h00, stb}, 16'h0000);
        @(posedge mclk) nrst <= 1'b1;
        wt(4);
        rd(1'b0, 3'h1, 16'hffff, "rise after reset");
        $display("test second reset done");
        close_out();
    end
endmodule // tb_top
bind hmsg_status hmsg_status_sva #(.WIDTH(WIDTH)) u_sva (.mclk(mclk), .nrst(nrst),
    .oper_meas_enable(oper_meas_enable), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_group(cmd_group), .cmd_sel(cmd_sel), .rd_data(rd_data), .rd_valid(rd_valid),
    .status_byte_bits(status_byte_bits), .meas_summary_message_bit(meas_summary_message_bit));
`default_nettype wire
